// File: src/rcs_sequencer.v
// command state machine: start, abort, transmit, receive, transceive
`timescale 1ns/1ns

// Function
// R1: host write of a code into command register starts that command.
// R2: command data passes through the shared fifo.
// R3: stream commands start draining fifo data at once.
// R4: argument commands wait for the exact argument byte count; no argument commands are implemented here.
// R5: starting a command never clears the fifo.
// R6: new code aborts running command; power-up init cannot be aborted.
// R7: code 3f runs power-up init only after reset, never from host.
// R8: code 00 is idle and cancels the running command.
// R9: code 1a sends fifo data to card, receives nothing.
// R10: code 16 enables receiver after receive wait, stores data in fifo.
// R11: host uses stand-alone receive only for tests.
// R12: code 1e transmits, then receives after receive wait automatically.
// R13: completed commands return to idle, register reads idle code.
module rcs_sequencer (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       cmd_wr,
    input  wire [5:0] cmd_wdata,
    input  wire [7:0] receive_delay_setting,
    input  wire       fifo_empty,
    input  wire [7:0] fifo_rdata,
    input  wire       fifo_full,
    input  wire       tx_ready,
    input  wire       rx_valid_async,
    input  wire [7:0] rx_data,
    input  wire       rx_end_async,
    output reg  [5:0] cmd_rdata,
    output reg        busy,
    output reg        fifo_rd,
    output reg        fifo_wr,
    output reg  [7:0] fifo_wdata,
    output reg        tx_valid,
    output reg  [7:0] tx_data,
    output reg        tx_last,
    output reg        rx_enable,
    output reg        power_up_init_cmd
);

`include "rcs_defines.vh"

// ----------------------------------------
// states
// ----------------------------------------
localparam ST_INIT = 3'd0;
localparam ST_IDLE = 3'd1;
localparam ST_TX   = 3'd2;
localparam ST_WAIT = 3'd3;
localparam ST_RX   = 3'd4;

reg  [2:0] state_r;
reg  [2:0] state_nxt;
reg  [7:0] init_cnt_r;
reg        rx_after_r;
reg  [1:0] rxv_sync_r;
reg  [1:0] rxe_sync_r;
reg        rxv_d_r;
reg        wait_start_r;
wire       wait_done;
wire       rxv_rise;
wire       host_cmd;
wire       cmd_ok;

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        rxv_sync_r <= 2'b00;
        rxe_sync_r <= 2'b00;
        rxv_d_r    <= 1'b0;
    end else begin
        rxv_sync_r <= {rxv_sync_r[0], rx_valid_async};
        rxe_sync_r <= {rxe_sync_r[0], rx_end_async};
        rxv_d_r    <= rxv_sync_r[1];
    end
end

assign rxv_rise = rxv_sync_r[1] & ~rxv_d_r;

// host write accepted unless init runs; code 3f from host acts as idle and cancels the running command
assign host_cmd = cmd_wr && (state_r != ST_INIT);                        // see R6
assign cmd_ok   = (cmd_wdata == `RCS_CMD_IDLE) || (cmd_wdata == `RCS_CMD_TRANSMIT) ||
                  (cmd_wdata == `RCS_CMD_RECEIVE) || (cmd_wdata == `RCS_CMD_TRANSCEIVE);

rcs_wait_timer u_wait (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .start    (wait_start_r),
    .abort    (host_cmd),
    .wait_len (receive_delay_setting),
    .done     (wait_done)
);

// ----------------------------------------
// next state
// ----------------------------------------
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_INIT: begin
            if (init_cnt_r == 8'h00)
                state_nxt = ST_IDLE;                                     // see R7
        end
        ST_TX: begin
            if (tx_ready && fifo_empty)
                state_nxt = rx_after_r ? ST_WAIT : ST_IDLE;               // see R12
        end
        ST_WAIT: begin
            if (wait_done)
                state_nxt = ST_RX;                                       // see R10
        end
        ST_RX: begin
            if (rxe_sync_r[1])
                state_nxt = ST_IDLE;                                     // see R13
        end
        ST_IDLE: begin
            state_nxt = ST_IDLE;
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
    if (host_cmd) begin                                                  // see R1
        case (cmd_wdata)
            `RCS_CMD_TRANSMIT:   state_nxt = ST_TX;                      // see R9
            `RCS_CMD_TRANSCEIVE: state_nxt = ST_TX;                      // see R12
            `RCS_CMD_RECEIVE:    state_nxt = ST_WAIT;                    // see R10
            default:             state_nxt = ST_IDLE;                    // see R8
        endcase
    end
end

// ----------------------------------------
// registers and outputs
// ----------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_r           <= ST_INIT;                                    // see R7
        init_cnt_r        <= `RCS_INIT_CYCLES;
        rx_after_r        <= 1'b0;
        wait_start_r      <= 1'b0;
        cmd_rdata         <= `RCS_CMD_POWER_UP_INIT_CMD;
        busy              <= 1'b1;
        fifo_rd           <= 1'b0;
        fifo_wr           <= 1'b0;
        fifo_wdata        <= 8'h00;
        tx_valid          <= 1'b0;
        tx_data           <= 8'h00;
        tx_last           <= 1'b0;
        rx_enable         <= 1'b0;
        power_up_init_cmd <= 1'b1;
    end else begin
        state_r      <= state_nxt;
        wait_start_r <= 1'b0;
        fifo_rd      <= 1'b0;
        fifo_wr      <= 1'b0;
        tx_last      <= 1'b0;
        if (state_r == ST_INIT && init_cnt_r != 8'h00)
            init_cnt_r <= init_cnt_r - 8'h01;
        power_up_init_cmd <= (state_nxt == ST_INIT);
        busy <= (state_nxt != ST_IDLE);
        if (host_cmd) begin
            rx_after_r <= (cmd_wdata == `RCS_CMD_TRANSCEIVE);
            cmd_rdata  <= cmd_ok ? cmd_wdata : `RCS_CMD_IDLE;
            // fifo is left untouched here; preloaded data stays            see R5
        end else if (state_nxt == ST_IDLE) begin
            cmd_rdata <= `RCS_CMD_IDLE;                                  // see R13
        end
        if ((state_nxt == ST_WAIT) && (state_r != ST_WAIT || host_cmd))
            wait_start_r <= 1'b1;                                        // see R10
        // stream drain: at most one fifo byte every other clock cycle, never two cycles in a row       see R2 R3
        // no argument commands: nothing waits on a byte count          see R4
        tx_valid <= 1'b0;
        if (state_r == ST_TX && !host_cmd && tx_ready && !fifo_empty && !fifo_rd) begin
            fifo_rd  <= 1'b1;
            tx_valid <= 1'b1;
            tx_data  <= fifo_rdata;
        end
        if (state_r == ST_TX && state_nxt != ST_TX && !host_cmd)
            tx_last <= 1'b1;
        rx_enable <= (state_nxt == ST_RX);                               // see R10
        if (state_r == ST_RX && !host_cmd && rxv_rise && !fifo_full) begin
            fifo_wr    <= 1'b1;                                          // see R12
            fifo_wdata <= rx_data;
        end
    end
end

endmodule // rcs_sequencer

// File: src/rcs_defines.vh
// command codes and timing constants of the reader command sequencer
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH

`define RCS_CMD_IDLE       6'h00
`define RCS_CMD_TRANSMIT   6'h1a
`define RCS_CMD_RECEIVE    6'h16
`define RCS_CMD_TRANSCEIVE 6'h1e
`define RCS_CMD_POWER_UP_INIT_CMD    6'h3f

`define RCS_INIT_CYCLES    8'h20
`define RCS_WAIT_W         8
`define RCS_BIT_DIV        4'h8

`endif

// File: src/rcs_wait_timer.v
// receive-wait down counter paced by a bit-rate enable
`timescale 1ns/1ns
module rcs_wait_timer (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       start,
    input  wire       abort,
    input  wire [7:0] wait_len,
    output reg        done
);

`include "rcs_defines.vh"

reg  [3:0] div_r;
reg  [7:0] cnt_r;
reg        run_r;
wire       tick;

assign tick = (div_r == 4'h0);

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        div_r <= 4'h0;
        cnt_r <= 8'h00;
        run_r <= 1'b0;
        done  <= 1'b0;
    end else begin
        done <= 1'b0;
        div_r <= tick ? (`RCS_BIT_DIV - 4'h1) : (div_r - 4'h1);
        if (abort) begin
            run_r <= 1'b0;
        end else if (start) begin
            // restart the divider so the first unit is a full one
            div_r <= `RCS_BIT_DIV - 4'h1;
            run_r <= 1'b1;
            cnt_r <= wait_len;
        end else if (run_r && tick) begin
            if (cnt_r == 8'h00) begin
                run_r <= 1'b0;
                done  <= 1'b1;
            end else begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
end

endmodule // rcs_wait_timer

// File: dv/rcs_fifo_model.sv
// fifo buffer model between host and sequencer
`timescale 1ns/1ns
module rcs_fifo_model (
    input  wire       ref_clk,
    input  wire       fifo_rd,
    input  wire       fifo_wr,
    input  wire [7:0] fifo_wdata,
    input  wire       load,
    input  wire [7:0] load_data,
    output wire       fifo_empty,
    output wire       fifo_full,
    output wire [7:0] fifo_rdata,
    output wire [6:0] level
);
    logic [7:0] mem [0:63];
    logic [6:0] wp = 7'h00;
    logic [6:0] rp = 7'h00;
    wire        push = load || (fifo_wr && !fifo_full);
    assign level      = wp - rp;
    assign fifo_empty = level == 7'h00;
    assign fifo_full  = level == 7'h40;
    // empty head shows a moving pattern, not stale data
    assign fifo_rdata = fifo_empty ? {1'b1, ~wp} : mem[rp[5:0]];
    always @(posedge ref_clk) begin
        if (push)
            mem[wp[5:0]] <= load ? load_data : fifo_wdata;
        wp <= wp + {6'h00, push};
        rp <= rp + {6'h00, fifo_rd && !fifo_empty};
    end
endmodule // rcs_fifo_model

// File: dv/rcs_sequencer_sva.sv
// port assertions of the command sequencer
`timescale 1ns/1ns
module rcs_sequencer_chk (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       cmd_wr,
    input wire logic [5:0] cmd_wdata,
    input wire logic [5:0] cmd_rdata,
    input wire logic       busy,
    input wire logic       fifo_rd,
    input wire logic       fifo_wr,
    input wire logic       tx_valid,
    input wire logic       rx_enable,
    input wire logic       power_up_init_cmd
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take(logic [5:0] c);
        cmd_wr && !power_up_init_cmd && cmd_wdata == c;
    endsequence
    chk_init_code: assert property ($rose(rst_n) |-> power_up_init_cmd && cmd_rdata == 6'h3f)
        else $error("init not running after reset");
    chk_init_hold: assert property (power_up_init_cmd && cmd_wr |=> cmd_rdata inside {6'h3f, 6'h00})
        else $error("write taken during init");
    chk_take_tx: assert property (s_take(6'h1a) |=> busy && cmd_rdata == 6'h1a)
        else $error("transmit not started");
    chk_idle_stop: assert property (s_take(6'h00) |=> !busy && !rx_enable && cmd_rdata == 6'h00)
        else $error("idle did not cancel");
    chk_rx_wait: assert property (s_take(6'h16) |=> !rx_enable [*8])
        else $error("receiver on before wait");
    chk_tx_quiet: assert property (cmd_rdata == 6'h1a |-> !fifo_wr && !rx_enable)
        else $error("transmit stored data");
    chk_pop_pace: assert property (fifo_rd |-> tx_valid ##1 !fifo_rd)
        else $error("pop without byte or too close");
    chk_done_idle: assert property ($fell(busy) |-> cmd_rdata == 6'h00)
        else $error("finished but code not idle");
endmodule // rcs_sequencer_chk
bind rcs_sequencer rcs_sequencer_chk u_chk (.ref_clk, .rst_n, .cmd_wr, .cmd_wdata, .cmd_rdata,
    .busy, .fifo_rd, .fifo_wr, .tx_valid, .rx_enable, .power_up_init_cmd);

// File: dv/reader_command_sequencer_test.sv
// self-checking bench of the command sequencer
`timescale 1ns/1ns
module reader_command_sequencer_test;
    logic       ref_clk = 1'b0, rst_n = 1'b0, cmd_wr = 1'b0, tx_ready = 1'b1, load = 1'b0;
    logic       rx_valid_async = 1'b0, rx_end_async = 1'b0;
    logic [5:0] cmd_wdata = 6'h00;
    logic [7:0] receive_delay_setting = 8'h00, rx_data = 8'h00, load_data = 8'h00;
    wire        fifo_empty, fifo_full, fifo_rd, fifo_wr, busy, tx_valid, tx_last, rx_enable;
    wire        power_up_init_cmd;
    wire  [7:0] fifo_rdata, fifo_wdata, tx_data;
    wire  [5:0] cmd_rdata;
    wire  [6:0] level;
    logic [7:0] exp_q [$];
    int         mismatches = 0, comparisons = 0, n;
    always #2 ref_clk = ~ref_clk;
    rcs_sequencer u_rcs_sequencer (.ref_clk, .rst_n, .cmd_wr, .cmd_wdata, .receive_delay_setting,
        .fifo_empty, .fifo_rdata, .fifo_full, .tx_ready, .rx_valid_async, .rx_data, .rx_end_async,
        .cmd_rdata, .busy, .fifo_rd, .fifo_wr, .fifo_wdata, .tx_valid, .tx_data, .tx_last,
        .rx_enable, .power_up_init_cmd);
    rcs_fifo_model u_rcs_fifo_model (.ref_clk, .fifo_rd, .fifo_wr, .fifo_wdata, .load,
        .load_data, .fifo_empty, .fifo_full, .fifo_rdata, .level);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] d);
        exp_q.push_back(d);
        @(negedge ref_clk) {load, load_data} = {1'b1, d};
        @(negedge ref_clk) load = 1'b0;
    endtask
    task automatic cmd(input logic [5:0] c);
        @(negedge ref_clk) {cmd_wr, cmd_wdata} = {1'b1, c};
        @(negedge ref_clk) cmd_wr = 1'b0;
    endtask
    task automatic idle_wait;
        for (n = 0; busy !== 1'b0 && n < 2000; n++) @(negedge ref_clk);
        chk(busy, 8'h00);
        chk(cmd_rdata, 8'h00);
    endtask
    task automatic send_out;
        for (n = 0; exp_q.size() > 0 && n < 500; n++) begin
            @(posedge ref_clk) #1;
            if (tx_valid === 1'b1) chk(tx_data, exp_q.pop_front());
        end
        chk(8'(exp_q.size()), 8'h00);
    endtask
    task automatic t_init;
        chk(cmd_rdata, 8'h3f);
        cmd(6'h1a);
        chk(cmd_rdata, 8'h3f);
        idle_wait;
        cmd(6'h3f);
        chk(power_up_init_cmd, 8'h00);
        $display("init test done");
    endtask
    task automatic t_tx;
        tx_ready = 1'b0;
        put(8'ha5);
        put(8'h5a);
        put(8'h3c);
        cmd(6'h1a);
        chk({1'b0, level}, 8'h03);
        tx_ready = 1'b1;
        send_out;
        for (n = 0; tx_last !== 1'b1 && n < 20; n++) @(posedge ref_clk) #1;
        chk(tx_last, 8'h01);
        idle_wait;
        chk({1'b0, level}, 8'h00);
        $display("transmit test done");
    endtask
    task automatic t_abort;
        cmd(6'h16);
        chk(cmd_rdata, 8'h16);
        cmd(6'h00);
        chk(busy, 8'h00);
        chk(cmd_rdata, 8'h00);
        $display("abort test done");
    endtask
    task automatic t_trx;
        receive_delay_setting = 8'h01;
        put(8'h81);
        cmd(6'h1e);
        send_out;
        for (n = 0; rx_enable !== 1'b1 && n < 100; n++) @(negedge ref_clk);
        chk(n > 4 && n < 100, 8'h01);
        {rx_data, rx_valid_async} = {8'h66, 1'b1};
        repeat (4) @(negedge ref_clk);
        rx_valid_async = 1'b0;
        rx_end_async = 1'b1;
        repeat (4) @(negedge ref_clk);
        rx_end_async = 1'b0;
        idle_wait;
        chk(fifo_rdata, 8'h66);
        chk(rx_enable, 8'h00);
        $display("transceive test done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        t_init;
        t_tx;
        t_abort;
        t_trx;
        report_and_stop;
    end
    initial begin
        #20000;
        mismatches++;
        report_and_stop;
    end
endmodule // reader_command_sequencer_test
